// ### hw/crcw_pkg.sv
// Package for the CRC width and polynomial configuration block.
// Assumes a 32-bit APB slave at 100 MHz with 16-bit registers in low bits.
`default_nettype none
package crcw_pkg;
    // ==================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_WIDTH_LENGTH_CONFIG = 8'h00;
    localparam logic [7:0] OFF_POLY_TAPS_LOW = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_SHIFT_DATA = 8'h0c;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // ==================================================
    // Field positions
    localparam int POLY_LENGTH_MINUS_ONE_LSB = 0;
    localparam int POLY_LENGTH_MINUS_ONE_MSB = 4;
    localparam int WORD_WIDTH_MINUS_ONE_LSB = 8;
    localparam int WORD_WIDTH_MINUS_ONE_MSB = 12;
    localparam logic [15:0] WIDTH_CFG_MASK = 16'h1f1f;
    localparam logic [15:0] POLY_LOW_MASK = 16'hfffe;
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_ISEL_BIT = 1;
    localparam int STS_BUSY_BIT = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_EMPTY_BIT = 1;
    // ==================================================
    // Reset values
    localparam logic [15:0] WIDTH_CFG_RESET = 16'h0000;
    localparam logic [15:0] POLY_LOW_RESET = 16'h0000;
    localparam logic [1:0] CTL_RESET = 2'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // ==================================================
    // Timing counts, in clock cycles
    localparam logic [1:0] LOAD_CYCLES = 2'h2;
    // ==================================================
    // Engine states
    typedef enum logic [1:0] {
        CRCW_IDLE = 2'b00,
        CRCW_LOAD = 2'b01,
        CRCW_SHIFT = 2'b10
    } crcw_state_e;
endpackage
`default_nettype wire

// ### hw/crcw_sticky.sv
// Sticky event flag with write-one-to-clear.
// Assumes event and clear arrive on SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module crcw_sticky (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hw/crcw_config.sv
// CRC width/length configuration, low polynomial taps and a small shifter.
// Assumes an APB master on SYS_CLK; RST is synchronous and active high.
// Notes on behaviour
// - Bits 4:0 of the width register hold polynomial length minus one.
// - Low polynomial bits 15:1 enable feedback XOR for that power of x.
// - Low polynomial bit 0 is absent, reads zero and ignores writes.
// - Width register bits 15:13 and 7:5 read zero and ignore writes.
// - With irq select zero, the interrupt comes only when shifting is done.
// - Clearing run suspends the calculation; setting it resumes it.
// - A word load takes two cycles, then (length field + 1)/2 shift cycles.
// - The input buffer is one 32-bit double word; the result buffer holds the 16-bit CRC with its upper half zero.
`timescale 1ns/1ps
`default_nettype none
module crcw_config (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [4:0] POLY_LENGTH_MINUS_ONE,
    output logic [4:0] WORD_WIDTH_MINUS_ONE,
    output logic [15:0] POLY_TAPS_LOW,
    output logic IRQ
);
    // ==================================================
    // Registers
    logic [15:0] width_length_config;
    logic [15:0] poly_taps_low;
    logic shifter_run;
    logic irq_source_select;
    logic [31:0] input_word_buffer;
    logic [31:0] result_word_buffer;
    logic [15:0] crc;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic word_pending;
    crcw_pkg::crcw_state_e state;
    logic [4:0] count;
    logic [31:0] shreg;
    logic ev_done;
    logic ev_empty;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] next_prdata;
    logic [4:0] shift_steps;

    // ==================================================
    // APB decode, zero wait states
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign rd = PSEL && !PENABLE && !PWRITE;
    always_comb begin
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        case (PADDR)
            crcw_pkg::OFF_WIDTH_LENGTH_CONFIG: begin
                next_prdata = {16'h0000, width_length_config};
            end
            crcw_pkg::OFF_POLY_TAPS_LOW: begin
                next_prdata = {16'h0000, poly_taps_low};
            end
            crcw_pkg::OFF_CONTROL: begin
                next_prdata[crcw_pkg::CTL_RUN_BIT] = shifter_run;
                next_prdata[crcw_pkg::CTL_ISEL_BIT] = irq_source_select;
                next_prdata[crcw_pkg::STS_BUSY_BIT] =
                    (state != crcw_pkg::CRCW_IDLE) || word_pending;
            end
            crcw_pkg::OFF_SHIFT_DATA: next_prdata = input_word_buffer;
            crcw_pkg::OFF_RESULT: next_prdata = result_word_buffer;
            crcw_pkg::OFF_IRQ_STATUS: next_prdata = {30'h0, irq_status};
            crcw_pkg::OFF_IRQ_MASK: next_prdata = {30'h0, irq_mask};
            default: mapped = 1'b0;
        endcase
    end

    // Read data captured in setup so it is stable in the access phase
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (rd || (PSEL && !PENABLE)) begin
            PRDATA <= rd ? next_prdata : 32'h0000_0000;
            PSLVERR <= !mapped;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
        end
    end

    // ==================================================
    // Configuration registers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            width_length_config <= crcw_pkg::WIDTH_CFG_RESET;
            poly_taps_low <= crcw_pkg::POLY_LOW_RESET;
        end else if (wr && PADDR == crcw_pkg::OFF_WIDTH_LENGTH_CONFIG) begin
            width_length_config <= PWDATA[15:0] & crcw_pkg::WIDTH_CFG_MASK;
        end else if (wr && PADDR == crcw_pkg::OFF_POLY_TAPS_LOW) begin
            poly_taps_low <= PWDATA[15:0] & crcw_pkg::POLY_LOW_MASK;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            {irq_source_select, shifter_run} <= crcw_pkg::CTL_RESET;
            irq_mask <= crcw_pkg::IRQ_RESET;
        end else if (wr && PADDR == crcw_pkg::OFF_CONTROL) begin
            shifter_run <= PWDATA[crcw_pkg::CTL_RUN_BIT];
            irq_source_select <= PWDATA[crcw_pkg::CTL_ISEL_BIT];
        end else if (wr && PADDR == crcw_pkg::OFF_IRQ_MASK) begin
            irq_mask <= PWDATA[1:0];
        end
    end

    // ==================================================
    // Input word buffer, one double word of pending data
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            input_word_buffer <= 32'h0000_0000;
            word_pending <= 1'b0;
        end else if (wr && PADDR == crcw_pkg::OFF_SHIFT_DATA) begin
            input_word_buffer <= PWDATA;
            word_pending <= 1'b1;
        end else if (shifter_run && state == crcw_pkg::CRCW_LOAD &&
                     count == crcw_pkg::LOAD_CYCLES - 2'h1) begin
            word_pending <= 1'b0;
        end
    end

    // ==================================================
    // Shift engine; two bits per cycle, hence the halved cycle count
    assign shift_steps = 5'((6'(width_length_config[crcw_pkg::POLY_LENGTH_MINUS_ONE_MSB:
        crcw_pkg::POLY_LENGTH_MINUS_ONE_LSB]) + 6'h1) >> 1);

    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic d,
                                         input logic [15:0] taps,
                                         input logic [4:0] top);
        logic fb;
        fb = c[top[3:0]] ^ d;
        step = ((c << 1) & ~(16'h0001)) ^ (fb ? (taps | 16'h0001) : 16'h0);
    endfunction

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= crcw_pkg::CRCW_IDLE;
            count <= 5'h00;
            shreg <= 32'h0000_0000;
            crc <= 16'h0000;
        end else if (shifter_run) begin
            case (state)
                crcw_pkg::CRCW_IDLE: begin
                    if (word_pending) begin
                        state <= crcw_pkg::CRCW_LOAD;
                        count <= 5'h00;
                    end
                end
                crcw_pkg::CRCW_LOAD: begin
                    if (count == 5'(crcw_pkg::LOAD_CYCLES - 2'h1)) begin
                        shreg <= input_word_buffer;
                        count <= 5'h00;
                        state <= crcw_pkg::CRCW_SHIFT;
                    end else begin
                        count <= count + 5'h01;
                    end
                end
                crcw_pkg::CRCW_SHIFT: begin
                    crc <= step(step(crc, shreg[31], poly_taps_low,
                        width_length_config[4:0]), shreg[30], poly_taps_low,
                        width_length_config[4:0]);
                    shreg <= {shreg[29:0], 2'b00};
                    if (count == shift_steps - 5'h01) begin
                        state <= crcw_pkg::CRCW_IDLE;
                    end else begin
                        count <= count + 5'h01;
                    end
                end
                default: state <= crcw_pkg::CRCW_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            result_word_buffer <= 32'h0000_0000;
        end else begin
            result_word_buffer <= {16'h0000, crc};
        end
    end

    // ==================================================
    // Events and interrupt
    assign ev_done = shifter_run && state == crcw_pkg::CRCW_SHIFT &&
        count == shift_steps - 5'h01;
    assign ev_empty = shifter_run && state == crcw_pkg::CRCW_LOAD &&
        count == 5'(crcw_pkg::LOAD_CYCLES - 2'h1);

    crcw_sticky u_done (
        .clk(SYS_CLK),
        .rst(RST),
        .set(ev_done),
        .clear(wr && PADDR == crcw_pkg::OFF_IRQ_STATUS &&
               PWDATA[crcw_pkg::IRQ_DONE_BIT]),
        .flag(irq_status[crcw_pkg::IRQ_DONE_BIT])
    );

    // Empty event only counts when selected; else done alone raises it
    crcw_sticky u_empty (
        .clk(SYS_CLK),
        .rst(RST),
        .set(ev_empty && irq_source_select),
        .clear(wr && PADDR == crcw_pkg::OFF_IRQ_STATUS &&
               PWDATA[crcw_pkg::IRQ_EMPTY_BIT]),
        .flag(irq_status[crcw_pkg::IRQ_EMPTY_BIT])
    );

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
            POLY_LENGTH_MINUS_ONE <= 5'h00;
            WORD_WIDTH_MINUS_ONE <= 5'h00;
            POLY_TAPS_LOW <= 16'h0000;
        end else begin
            IRQ <= |(irq_status & irq_mask);
            POLY_LENGTH_MINUS_ONE <= width_length_config[4:0];
            WORD_WIDTH_MINUS_ONE <= width_length_config[12:8];
            POLY_TAPS_LOW <= poly_taps_low;
        end
    end
endmodule
`default_nettype wire

// ### tb/crcw_config_asserts.sv
// Port checker for the CRC width and polynomial config block.
// Assumes a bind onto crcw_config; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module crcw_config_asserts (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [4:0] POLY_LENGTH_MINUS_ONE,
    input wire logic [4:0] WORD_WIDTH_MINUS_ONE,
    input wire logic [15:0] POLY_TAPS_LOW,
    input wire logic IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ==========================================
    // Access decode
    wire logic acc = PSEL && PENABLE && PREADY;
    wire logic wr0 = acc && PWRITE && PADDR == 8'h00;
    wire logic wr4 = acc && PWRITE && PADDR == 8'h04;
    wire logic rd0 = acc && !PWRITE && PADDR == 8'h00;
    wire logic rd4 = acc && !PWRITE && PADDR == 8'h04;
    // ==========================================
    // Properties
    // Copies lag the register by one cycle
    property p_len;
        wr0 |-> ##2 POLY_LENGTH_MINUS_ONE == $past(PWDATA[4:0], 2);
    endproperty
    a_len: assert property (p_len) else $error("length copy wrong");
    property p_wid;
        wr0 |-> ##2 WORD_WIDTH_MINUS_ONE == $past(PWDATA[12:8], 2);
    endproperty
    a_wid: assert property (p_wid) else $error("width copy wrong");
    property p_taps;
        wr4 |-> ##2 POLY_TAPS_LOW == ($past(PWDATA[15:0], 2) & 16'hfffe);
    endproperty
    a_taps: assert property (p_taps) else $error("taps copy wrong");
    property p_bit0;
        rd4 |-> PRDATA[0] == 1'b0 && PRDATA[31:16] == 16'h0000;
    endproperty
    a_bit0: assert property (p_bit0) else $error("tap bit 0 set");
    property p_rsv;
        rd0 |-> (PRDATA & 32'hffffe0e0) == 32'h00000000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rdcfg;
        rd0 |-> PRDATA[4:0] == POLY_LENGTH_MINUS_ONE
            && PRDATA[12:8] == WORD_WIDTH_MINUS_ONE;
    endproperty
    a_rdcfg: assert property (p_rdcfg) else $error("readback mismatch");
    property p_rst;
        $fell(RST) |-> POLY_LENGTH_MINUS_ONE == 5'h00
            && WORD_WIDTH_MINUS_ONE == 5'h00 && POLY_TAPS_LOW == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("fields not reset");
    property p_rdy;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    property p_err;
        acc && PADDR > 8'h18 |-> PSLVERR;
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    // Clearing the whole mask must drop the interrupt line
    property p_irq;
        acc && PWRITE && PADDR == 8'h18 && PWDATA[1:0] == 2'h0 |-> ##2 !IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("masked irq still high");
endmodule
bind crcw_config crcw_config_asserts u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POLY_LENGTH_MINUS_ONE(POLY_LENGTH_MINUS_ONE),
    .WORD_WIDTH_MINUS_ONE(WORD_WIDTH_MINUS_ONE),
    .POLY_TAPS_LOW(POLY_TAPS_LOW), .IRQ(IRQ));
`default_nettype wire

// ### tb/crcw_config_bench.sv
// Self-checking bench for the CRC width and polynomial config block.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module crcw_config_bench;
    logic SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, v;
    logic PREADY, PSLVERR, IRQ;
    logic [4:0] poly_length_minus_one, wwid;
    logic [15:0] taps;
    logic [32:0] expq[$];
    int n_fail = 0, n_checks = 0, seed = 32'he652d02f, k, t;
    always #5 SYS_CLK = ~SYS_CLK;
    crcw_config DUT (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .POLY_LENGTH_MINUS_ONE(poly_length_minus_one), .WORD_WIDTH_MINUS_ONE(wwid),
        .POLY_TAPS_LOW(taps), .IRQ(IRQ));
    // ==========================================
    // Tasks
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Reference shifter, MSB first, sixteen-bit polynomial 0x1021
    function automatic logic [15:0] crc_ref(input logic [15:0] c,
                                            input logic [15:0] d);
        logic fb;
        for (int i = 15; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    // Read expectation is queued; the monitor checks it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] x);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        if (!w)
            expq.push_back(x);
        @(posedge SYS_CLK);
        PENABLE <= 1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20)
            n_fail++;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        while (IRQ !== 1'b1 && c < 100) begin
            @(posedge SYS_CLK);
            c++;
        end
        if (c >= 100)
            n_fail++;
    endtask
    // ==========================================
    // Monitor and watchdog
    always @(posedge SYS_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            check({PSLVERR, PRDATA}, expq.pop_front());
    end
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        n_fail++;
        conclude();
    end
    // ==========================================
    // Scenarios
    initial begin
        repeat (20) @(posedge SYS_CLK);
        RST <= 0;
        apb(0, 8'h00, 0, 33'h0);
        apb(0, 8'h04, 0, 33'h0);
        for (k = 0; k < 12; k++) begin
            v = $random(seed);
            apb(1, 8'h00, v, 0);
            apb(0, 8'h00, 0, {1'b0, v & 32'h1f1f});
            apb(1, 8'h04, v, 0);
            apb(0, 8'h04, 0, {1'b0, v & 32'hfffe});
        end
        apb(1, 8'h1c, 32'hffff, 0);
        apb(0, 8'h1c, 0, {1'b1, 32'h0});
        // Sixteen-bit polynomial: eight shift cycles
        apb(1, 8'h00, 32'h0f0f, 0);
        apb(1, 8'h04, 32'h1021, 0);
        apb(1, 8'h18, 32'h3, 0);
        apb(1, 8'h08, 32'h0, 0);
        apb(1, 8'h0c, v, 0);
        repeat (30) @(posedge SYS_CLK);
        check({32'h0, IRQ}, 33'h0);
        apb(1, 8'h08, 32'h1, 0);
        wait_irq(t);
        check({32'h0, t >= 10 && t <= 16}, 33'h1);
        apb(0, 8'h0c, 0, {1'b0, v});
        apb(0, 8'h10, 0, {17'h0, crc_ref(16'h0, v[31:16])});
        apb(0, 8'h08, 0, 33'h1);
        apb(0, 8'h14, 0, 33'h1);
        apb(1, 8'h14, 32'h3, 0);
        apb(0, 8'h14, 0, 33'h0);
        @(posedge SYS_CLK);
        check({32'h0, IRQ}, 33'h0);
        // Empty source also flags the load
        apb(1, 8'h08, 32'h3, 0);
        apb(1, 8'h0c, v, 0);
        wait_irq(t);
        check({32'h0, t < 10}, 33'h1);
        repeat (20) @(posedge SYS_CLK);
        apb(0, 8'h14, 0, 33'h3);
        apb(0, 8'h10, 0,
            {17'h0, crc_ref(crc_ref(16'h0, v[31:16]), v[31:16])});
        apb(1, 8'h18, 32'h0, 0);
        repeat (2) @(posedge SYS_CLK);
        check({32'h0, IRQ}, 33'h0);
        conclude();
    end
endmodule
`default_nettype wire
